// ### bench/vsrb_host.sv
// host model: serial bus master and selector pin driver
`timescale 1ns/10ps
`default_nettype none
module vsrb_host (
	input wire logic i_clock,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda,
	output logic o_selector_pin_low,
	output logic o_selector_pin_high
);
	// bus idles released, pull-up gives a high level
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_selector_pin_low = 1'b0;
		o_selector_pin_high = 1'b0;
	end
	// set both lines just after an edge, then hold n cycles
	task automatic put(input logic c, input logic d, input int n);
		@(posedge i_clock);
		o_scl <= c;
		o_sda <= d;
		repeat (n - 1) @(posedge i_clock);
	endtask : put
	// start and repeated start share one shape
	task automatic start();
		put(1'b0, 1'b1, 2);
		put(1'b1, 1'b1, 4);
		put(1'b1, 1'b0, 4);
		put(1'b0, 1'b0, 2);
	endtask : start
	task automatic stop();
		put(1'b0, 1'b0, 2);
		put(1'b1, 1'b0, 4);
		put(1'b1, 1'b1, 4);
	endtask : stop
	// sda moves only with scl low; four cycles high keeps the slave's sampling safe
	task automatic xbit(input logic b, output logic q);
		put(1'b0, b, 2);
		put(1'b1, b, 4);
		q = i_sda;
		put(1'b0, b, 2);
	endtask : xbit
	// ninth bit: released for writes, master ack or nack for reads
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
		xbit(last, a);
		ack = ~a;
	endtask : xbyte
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$],
		output logic ack);
		logic [7:0] q;
		logic k;
		start();
		xbyte({a, 1'b0}, 1'b1, q, ack);
		xbyte(p, 1'b1, q, k);
		foreach (d[i]) begin
			xbyte(d[i], 1'b1, q, k);
		end
		stop();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
		output logic [7:0] q[$]);
		logic [7:0] b;
		logic k;
		start();
		xbyte({a, 1'b0}, 1'b1, b, k);
		xbyte(p, 1'b1, b, k);
		start();
		xbyte({a, 1'b1}, 1'b1, b, k);
		for (int i = 0; i < n; i++) begin
			xbyte(8'hff, i == n - 1, b, k);
			q.push_back(b);
		end
		stop();
	endtask : rd
	task automatic pins(input logic [1:0] s);
		@(posedge i_clock);
		o_selector_pin_high <= s[1];
		o_selector_pin_low <= s[0];
	endtask : pins
endmodule : vsrb_host
`default_nettype wire

// ### bench/vsrb_top_test.sv
// self-checking bench for the voltage setting register bank
`timescale 1ns/10ps
`default_nettype none
module vsrb_top_test import vsrb_pkg::*;;
	localparam logic [6:0] ADDR7 = 7'h60;
	localparam logic [6:0] ADDR6 = 7'h61;
	localparam logic [7:0] ID_A = 8'h5c; // arbitrary value
	localparam logic [7:0] ID_B = 8'h17; // arbitrary value
	logic i_clock, i_nrst, scl, h_sda, sda_w, sel_lo, sel_hi;
	logic sda7, oe7, sda6, oe6, pwm7, pwm6, ack;
	logic [6:0] code7, code6;
	logic [10:0] mv7, mv6;
	logic [7:0] d;
	logic [1:0] s;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 16785;
	logic [18:0] exp_q[$], seen_q[$];
	string nm_q[$];
	logic [7:0] regs7[4], regs6[4], rq[$];
	// open-drain wire: any party pulling low wins
	assign sda_w = h_sda & (oe7 ? sda7 : 1'b1) & (oe6 ? sda6 : 1'b1);
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	vsrb_host host_u (.i_clock(i_clock), .i_sda(sda_w), .o_scl(scl), .o_sda(h_sda),
		.o_selector_pin_low(sel_lo), .o_selector_pin_high(sel_hi));
	vsrb_top #(.p_slave_address(ADDR7), .p_identity_a(ID_A), .p_identity_b(ID_B)) dut_u (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda7),
		.o_sda_oe(oe7), .i_selector_pin_low(sel_lo), .i_selector_pin_high(sel_hi),
		.o_forced_pwm(pwm7), .o_voltage_code(code7), .o_target_mv(mv7));
	// second variant on the same bus: six bit code, full scale setting 0
	vsrb_top #(.p_code_bits(6), .p_full_scale_default(1'b1), .p_slave_address(ADDR6)) dut6_u (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda6),
		.o_sda_oe(oe6), .i_selector_pin_low(sel_lo), .i_selector_pin_high(sel_hi),
		.o_forced_pwm(pwm6), .o_voltage_code(code6), .o_target_mv(mv6));
	task automatic check(input string nm, input logic [18:0] sv, input logic [18:0] ev);
		samples_checked++;
		if (sv !== ev) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, ev, sv);
		end
	endtask : check
	// watcher pairs each observed result with the oldest note
	initial forever begin
		wait (seen_q.size() > 0);
		check(nm_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
	end
	task automatic note(input string nm, input logic [18:0] ev);
		nm_q.push_back(nm);
		exp_q.push_back(ev);
	endtask : note
	// expected mode, code and millivolts of one setting byte
	function automatic logic [18:0] outv(input logic [7:0] r, input logic six);
		logic [6:0] c;
		c = six ? {1'b0, r[5:0]} : r[6:0];
		return {r[7], c, (six ? VSRB_BASE_MV_6 : VSRB_BASE_MV_7) + 11'(c) * VSRB_STEP_MV};
	endfunction : outv
	// outputs lag pins by one cycle; three cycles leaves margin
	task automatic look(input logic [1:0] sel);
		host_u.pins(sel);
		repeat (3) @(posedge i_clock);
		note("out7", outv(regs7[sel], 1'b0));
		note("out6", outv(regs6[sel], 1'b1));
		seen_q.push_back({pwm7, code7, mv7});
		seen_q.push_back({pwm6, code6, mv6});
	endtask : look
	task automatic rd_all(input logic [6:0] a, input logic [7:0] p, input logic [7:0] e[$]);
		rq = {};
		host_u.rd(a, p, e.size(), rq);
		foreach (e[i]) begin
			note($sformatf("reg %h", p + 8'(i)), {11'h000, e[i]});
			seen_q.push_back({11'h000, rq[i]});
		end
	endtask : rd_all
	task automatic wr_one(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v[$],
		input logic exp_ack);
		host_u.wr(a, p, v, ack);
		note("ack", {18'h0_0000, exp_ack});
		seen_q.push_back({18'h0_0000, ack});
	endtask : wr_one
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	// a run needs some 12000 cycles; this cuts a hang
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		i_nrst = 1'b0;
		regs7 = '{8'h2e, 8'h5a, 8'h42, 8'h42};
		regs6 = '{8'h3f, 8'h1a, 8'h02, 8'h02};
		repeat (4) @(posedge i_clock);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clock);
		// reset values, identity bytes and an unmapped slot past the table
		rd_all(ADDR7, 8'h00, '{8'h2e, 8'h5a, 8'h42, 8'h42, 8'he0, 8'h00, 8'h00, 8'h00,
			ID_A, ID_B, 8'h00});
		rd_all(ADDR6, 8'h00, '{8'h3f, 8'h1a, 8'h02, 8'h02});
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			look(2'(i));
		end
		$display("selector walk done");
		// masked auxiliary bits; reserved and identity slots drop writes
		wr_one(ADDR7, 8'h04, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, 1'b1);
		rd_all(ADDR7, 8'h04, '{8'he0, 8'h07, 8'he6, 8'h00, ID_A, ID_B});
		// foreign address is not acknowledged and changes nothing
		wr_one(7'h22, 8'h00, '{8'h80}, 1'b0);
		look(2'b00);
		$display("access kinds done");
		// rewrite the active setting with random data, both variants
		for (int i = 0; i < 10; i++) begin
			s = 2'($random(seed));
			d = 8'($random(seed));
			host_u.pins(s);
			wr_one(ADDR7, {6'h00, s}, '{d}, 1'b1);
			wr_one(ADDR6, {6'h00, s}, '{d}, 1'b1);
			regs7[s] = d;
			regs6[s] = d & 8'hbf;
			look(s);
			rd_all(ADDR6, {6'h00, s}, '{regs6[s]});
		end
		// mid-run reset must bring every setting back, bus idle meanwhile
		i_nrst <= 1'b0;
		repeat (4) @(posedge i_clock);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clock);
		regs7 = '{8'h2e, 8'h5a, 8'h42, 8'h42};
		regs6 = '{8'h3f, 8'h1a, 8'h02, 8'h02};
		rd_all(ADDR7, 8'h00, '{8'h2e, 8'h5a, 8'h42, 8'h42});
		rd_all(ADDR6, 8'h00, '{8'h3f, 8'h1a});
		for (int i = 3; i >= 0; i--) begin
			look(2'(i));
		end
		$display("random rewrites and mid-run reset done");
		wait (seen_q.size() == 0);
		repeat (2) @(posedge i_clock);
		report_and_stop();
	end
endmodule : vsrb_top_test
`default_nettype wire

// ### hw/vsrb_pkg.sv
// constants shared by the voltage setting register bank
package vsrb_pkg;
	// register indices as seen through the serial pointer
	localparam logic [7:0] VSRB_ADDR_VOLTAGE_SETTING_0 = 8'h00;
	localparam logic [7:0] VSRB_ADDR_VOLTAGE_SETTING_1 = 8'h01;
	localparam logic [7:0] VSRB_ADDR_VOLTAGE_SETTING_2 = 8'h02;
	localparam logic [7:0] VSRB_ADDR_VOLTAGE_SETTING_3 = 8'h03;
	localparam logic [7:0] VSRB_ADDR_PULLDOWN = 8'h04;
	localparam logic [7:0] VSRB_ADDR_THERMAL = 8'h05;
	localparam logic [7:0] VSRB_ADDR_RAMP = 8'h06;
	localparam logic [7:0] VSRB_ADDR_RESERVED = 8'h07;
	localparam logic [7:0] VSRB_ADDR_ID_A = 8'h08;
	localparam logic [7:0] VSRB_ADDR_ID_B = 8'h09;
	localparam int VSRB_NUM_SETTINGS = 4;

	// field layout of a voltage setting register
	localparam int VSRB_MODE_BIT = 7;
	localparam int VSRB_CODE_BITS_6 = 6;
	localparam int VSRB_CODE_BITS_7 = 7;
	localparam logic [7:0] VSRB_SET_MASK_6 = 8'h00bf;
	localparam logic [7:0] VSRB_SET_MASK_7 = 8'h00ff;
	localparam logic [6:0] VSRB_CODE_MASK_6 = 7'h3f;
	localparam logic [6:0] VSRB_CODE_MASK_7 = 7'h7f;
	localparam logic [5:0] VSRB_FULL_SCALE_CODE_6 = 6'h3f;

	// reset values
	localparam logic [7:0] VSRB_VOLTAGE_SETTING_0_RESET = 8'h002e;
	localparam logic [7:0] VSRB_VOLTAGE_SETTING_1_RESET = 8'h005a;
	localparam logic [7:0] VSRB_VOLTAGE_SETTING_2_RESET = 8'h0042;
	localparam logic [7:0] VSRB_VOLTAGE_SETTING_3_RESET = 8'h0042;
	localparam logic [7:0] VSRB_PULLDOWN_RESET = 8'h00e0;
	localparam logic [7:0] VSRB_THERMAL_RESET = 8'h0000;
	localparam logic [7:0] VSRB_RAMP_RESET = 8'h0000;

	// implemented bits of the auxiliary registers
	localparam logic [7:0] VSRB_PULLDOWN_MASK = 8'h00e0;
	localparam logic [7:0] VSRB_THERMAL_MASK = 8'h0007;
	localparam logic [7:0] VSRB_RAMP_MASK = 8'h00e6;

	// output voltage arithmetic in millivolts
	localparam logic [10:0] VSRB_STEP_MV = 11'h00a;
	localparam logic [10:0] VSRB_BASE_MV_6 = 11'h302;
	localparam logic [10:0] VSRB_BASE_MV_7 = 11'h1f4;
	localparam logic [10:0] VSRB_TOP_MV_6 = 11'h578;
	localparam logic [10:0] VSRB_TOP_MV_7 = 11'h6ea;

	// serial framing
	localparam logic [3:0] VSRB_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] VSRB_BIT_COUNT_ZERO = 4'h0;
	localparam logic [3:0] VSRB_BIT_COUNT_ONE = 4'h1;
	localparam int VSRB_RW_BIT = 0;
endpackage : vsrb_pkg

// ### hw/vsrb_select.sv
// selector stage: picks the active setting and forms the regulator target
`timescale 1ns/10ps
`default_nettype none
module vsrb_select import vsrb_pkg::*; #(
	parameter int p_code_bits = 7
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_selector_pin_low,
	input wire logic i_selector_pin_high,
	input wire logic [7:0] i_setting_0,
	input wire logic [7:0] i_setting_1,
	input wire logic [7:0] i_setting_2,
	input wire logic [7:0] i_setting_3,
	output logic o_forced_pwm,
	output logic [6:0] o_voltage_code,
	output logic [10:0] o_target_mv
);
	localparam logic [6:0] code_mask = (p_code_bits == VSRB_CODE_BITS_6) ?
		VSRB_CODE_MASK_6 : VSRB_CODE_MASK_7;
	localparam logic [10:0] base_mv = (p_code_bits == VSRB_CODE_BITS_6) ?
		VSRB_BASE_MV_6 : VSRB_BASE_MV_7;
	localparam logic [10:0] top_mv = (p_code_bits == VSRB_CODE_BITS_6) ?
		VSRB_TOP_MV_6 : VSRB_TOP_MV_7;

	logic [7:0] chosen;
	logic [6:0] next_voltage_code;
	logic [10:0] next_target_mv;

	// pin pair selects one of four settings, high pin is the msb
	always_comb begin
		case ({i_selector_pin_high, i_selector_pin_low})
			2'b00: chosen = i_setting_0;
			2'b01: chosen = i_setting_1;
			2'b10: chosen = i_setting_2;
			default: chosen = i_setting_3;
		endcase
		next_voltage_code = chosen[6:0] & code_mask;
		next_target_mv = base_mv + {4'h0, next_voltage_code} * VSRB_STEP_MV;
	end

	// registered so the regulator never sees a decode glitch; costs one cycle
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_forced_pwm <= 1'b0;
			o_voltage_code <= 7'h00;
			o_target_mv <= base_mv;
		end else begin
			o_forced_pwm <= chosen[VSRB_MODE_BIT];
			o_voltage_code <= next_voltage_code;
			o_target_mv <= next_target_mv;
		end
	end

	property p_first_setting;
		@(posedge i_clock) disable iff (!i_nrst)
		(i_nrst && !i_selector_pin_high && !i_selector_pin_low)
			|=> o_voltage_code == ($past(i_setting_0[6:0]) & code_mask);
	endproperty
	a_first_setting: assert property (p_first_setting) else $error("setting 0 not applied");

	property p_second_setting;
		@(posedge i_clock) disable iff (!i_nrst)
		(i_nrst && !i_selector_pin_high && i_selector_pin_low)
			|=> o_voltage_code == ($past(i_setting_1[6:0]) & code_mask)
			&& o_forced_pwm == $past(i_setting_1[VSRB_MODE_BIT]);
	endproperty
	a_second_setting: assert property (p_second_setting) else $error("setting 1 not applied");

	property p_mode_bit;
		@(posedge i_clock) disable iff (!i_nrst)
		(i_nrst && i_selector_pin_high && !i_selector_pin_low)
			|=> o_forced_pwm == $past(i_setting_2[VSRB_MODE_BIT]);
	endproperty
	a_mode_bit: assert property (p_mode_bit) else $error("mode bit not passed on");

	property p_target_formula;
		@(posedge i_clock) disable iff (!i_nrst)
		o_target_mv == base_mv + {4'h0, o_voltage_code} * VSRB_STEP_MV
			&& o_target_mv <= top_mv && o_target_mv >= base_mv;
	endproperty
	a_target_formula: assert property (p_target_formula) else $error("target voltage wrong");

	property p_pin_change;
		@(posedge i_clock) disable iff (!i_nrst)
		(i_nrst && ($changed(i_selector_pin_high) || $changed(i_selector_pin_low)))
			##1 ($stable(i_selector_pin_high) && $stable(i_selector_pin_low))
			|-> o_voltage_code == ($past(chosen[6:0]) & code_mask);
	endproperty
	a_pin_change: assert property (p_pin_change) else $error("pin change not followed");

	c_pin_change: cover property (@(posedge i_clock) disable iff (!i_nrst)
		$changed(i_selector_pin_high) ##1 $changed(o_voltage_code));
endmodule : vsrb_select
`default_nettype wire

// ### hw/vsrb_top.sv
// voltage setting register bank with serial slave and selector pins
`timescale 1ns/10ps
`default_nettype none
module vsrb_top import vsrb_pkg::*; #(
	parameter int p_code_bits = 7,
	parameter logic p_full_scale_default = 1'b0,
	parameter logic [6:0] p_slave_address = 7'h60, // arbitrary value
	parameter logic [7:0] p_identity_a = 8'h00a5, // arbitrary value
	parameter logic [7:0] p_identity_b = 8'h003c // arbitrary value
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_selector_pin_low,
	input wire logic i_selector_pin_high,
	output logic o_forced_pwm,
	output logic [6:0] o_voltage_code,
	output logic [10:0] o_target_mv
);
	localparam logic [7:0] set_mask = (p_code_bits == VSRB_CODE_BITS_6) ?
		VSRB_SET_MASK_6 : VSRB_SET_MASK_7;

	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_ack_addr,
		st_ptr,
		st_ack_ptr,
		st_wdata,
		st_ack_wdata,
		st_tx,
		st_mack
	} vsrb_state_t;

	vsrb_state_t state;
	logic [3:0] bit_count;
	logic [7:0] shift;
	logic [7:0] pointer;
	logic read_mode;
	logic master_ack;
	logic scl_q;
	logic sda_q;
	logic [7:0] setting [VSRB_NUM_SETTINGS];
	logic [7:0] pulldown_control;
	logic [7:0] thermal_control;
	logic [7:0] ramp_control;
	logic [7:0] read_byte;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic wr_en;

	// reset value of each setting register
	function automatic logic [7:0] set_reset(input int idx);
		logic [7:0] value;
		value = VSRB_VOLTAGE_SETTING_0_RESET;
		if (idx == 1) begin
			value = VSRB_VOLTAGE_SETTING_1_RESET;
		end else if (idx == 2) begin
			value = VSRB_VOLTAGE_SETTING_2_RESET;
		end else if (idx == 3) begin
			value = VSRB_VOLTAGE_SETTING_3_RESET;
		end else if (p_code_bits == VSRB_CODE_BITS_6 && p_full_scale_default) begin
			value = {2'b00, VSRB_FULL_SCALE_CODE_6};
		end
		return value & set_mask;
	endfunction : set_reset

	// readback decode, used both at read start and after each master ack
	function automatic logic [7:0] read_reg(input logic [7:0] addr);
		logic [7:0] value;
		value = 8'h00;
		if (addr == VSRB_ADDR_VOLTAGE_SETTING_0) begin
			value = setting[0];
		end else if (addr == VSRB_ADDR_VOLTAGE_SETTING_1) begin
			value = setting[1];
		end else if (addr == VSRB_ADDR_VOLTAGE_SETTING_2) begin
			value = setting[2];
		end else if (addr == VSRB_ADDR_VOLTAGE_SETTING_3) begin
			value = setting[3];
		end else if (addr == VSRB_ADDR_PULLDOWN) begin
			value = pulldown_control;
		end else if (addr == VSRB_ADDR_THERMAL) begin
			value = thermal_control;
		end else if (addr == VSRB_ADDR_RAMP) begin
			value = ramp_control;
		end else if (addr == VSRB_ADDR_ID_A) begin
			value = p_identity_a;
		end else if (addr == VSRB_ADDR_ID_B) begin
			value = p_identity_b;
		end
		return value;
	endfunction : read_reg

	// line history for edge and start/stop detection; pins are synchronous
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	assign scl_rise = i_scl && !scl_q;
	assign scl_fall = !i_scl && scl_q;
	assign bus_start = i_scl && scl_q && sda_q && !i_sda;
	assign bus_stop = i_scl && scl_q && !sda_q && i_sda;
	assign wr_en = scl_fall && state == st_wdata && bit_count == VSRB_BITS_PER_BYTE;

	// readback byte; a process so the register reads inside the function are tracked
	always_comb begin
		read_byte = read_reg(pointer);
	end

	// open drain: the line is only ever pulled low
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_sda <= 1'b0;
		end else begin
			o_sda <= 1'b0;
		end
	end

	// serial slave; sample on scl rise, change sda on scl fall
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			state <= st_idle;
			bit_count <= VSRB_BIT_COUNT_ZERO;
			shift <= 8'h00;
			pointer <= 8'h00;
			read_mode <= 1'b0;
			master_ack <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (bus_stop) begin
			state <= st_idle;
			o_sda_oe <= 1'b0;
		end else if (bus_start) begin
			state <= st_addr;
			bit_count <= VSRB_BIT_COUNT_ZERO;
			o_sda_oe <= 1'b0;
		end else if (scl_rise) begin
			case (state)
				st_addr, st_ptr, st_wdata: begin
					shift <= {shift[6:0], i_sda};
					bit_count <= bit_count + VSRB_BIT_COUNT_ONE;
				end
				st_tx: begin
					bit_count <= bit_count + VSRB_BIT_COUNT_ONE;
				end
				st_mack: begin
					master_ack <= !i_sda;
					pointer <= pointer + 8'h01; // auto increment after each byte sent
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				st_addr: begin
					if (bit_count == VSRB_BITS_PER_BYTE) begin
						if (shift[7:1] == p_slave_address) begin
							read_mode <= shift[VSRB_RW_BIT];
							o_sda_oe <= 1'b1;
							state <= st_ack_addr;
						end else begin
							state <= st_idle; // not ours, wait for next start
						end
					end
				end
				st_ptr: begin
					if (bit_count == VSRB_BITS_PER_BYTE) begin
						pointer <= shift;
						o_sda_oe <= 1'b1;
						state <= st_ack_ptr;
					end
				end
				st_wdata: begin
					if (bit_count == VSRB_BITS_PER_BYTE) begin
						pointer <= pointer + 8'h01;
						o_sda_oe <= 1'b1;
						state <= st_ack_wdata;
					end
				end
				st_ack_addr: begin
					bit_count <= VSRB_BIT_COUNT_ZERO;
					if (read_mode) begin
						shift <= read_byte;
						o_sda_oe <= !read_byte[7];
						state <= st_tx;
					end else begin
						o_sda_oe <= 1'b0;
						state <= st_ptr;
					end
				end
				st_ack_ptr, st_ack_wdata: begin
					bit_count <= VSRB_BIT_COUNT_ZERO;
					o_sda_oe <= 1'b0;
					state <= st_wdata;
				end
				st_tx: begin
					if (bit_count == VSRB_BITS_PER_BYTE) begin
						o_sda_oe <= 1'b0;
						state <= st_mack;
					end else begin
						shift <= {shift[6:0], 1'b0};
						o_sda_oe <= !shift[6];
					end
				end
				st_mack: begin
					if (master_ack) begin
						bit_count <= VSRB_BIT_COUNT_ZERO;
						shift <= read_byte;
						o_sda_oe <= !read_byte[7];
						state <= st_tx;
					end else begin
						o_sda_oe <= 1'b0;
						state <= st_idle;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// register file; reserved, identity and unmapped writes are dropped
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			for (int i = 0; i < VSRB_NUM_SETTINGS; i++) begin
				setting[i] <= set_reset(i);
			end
			pulldown_control <= VSRB_PULLDOWN_RESET;
			thermal_control <= VSRB_THERMAL_RESET;
			ramp_control <= VSRB_RAMP_RESET;
		end else if (wr_en) begin
			if (pointer <= VSRB_ADDR_VOLTAGE_SETTING_3) begin
				setting[pointer[1:0]] <= shift & set_mask;
			end else if (pointer == VSRB_ADDR_PULLDOWN) begin
				pulldown_control <= shift & VSRB_PULLDOWN_MASK;
			end else if (pointer == VSRB_ADDR_THERMAL) begin
				thermal_control <= shift & VSRB_THERMAL_MASK;
			end else if (pointer == VSRB_ADDR_RAMP) begin
				ramp_control <= shift & VSRB_RAMP_MASK;
			end
		end
	end

	// selection and target forming live in the selector stage
	vsrb_select #(
		.p_code_bits(p_code_bits)
	) u_select (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_selector_pin_low(i_selector_pin_low),
		.i_selector_pin_high(i_selector_pin_high),
		.i_setting_0(setting[0]),
		.i_setting_1(setting[1]),
		.i_setting_2(setting[2]),
		.i_setting_3(setting[3]),
		.o_forced_pwm(o_forced_pwm),
		.o_voltage_code(o_voltage_code),
		.o_target_mv(o_target_mv)
	);

	property p_reset_values;
		@(posedge i_clock) disable iff (!i_nrst)
		$rose(i_nrst) |-> setting[0][VSRB_MODE_BIT] == 1'b0
			&& setting[0][5:0] == ((p_code_bits == VSRB_CODE_BITS_6 && p_full_scale_default) ?
			VSRB_FULL_SCALE_CODE_6 : VSRB_VOLTAGE_SETTING_0_RESET[5:0])
			&& setting[1] == (VSRB_VOLTAGE_SETTING_1_RESET & set_mask);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("setting reset wrong");

	property p_rewrite_active;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_en && pointer == {6'h00, i_selector_pin_high, i_selector_pin_low})
			##1 ($stable(i_selector_pin_high) && $stable(i_selector_pin_low))
			|=> o_voltage_code == $past(shift[6:0] & set_mask[6:0], 2)
			&& o_forced_pwm == $past(shift[VSRB_MODE_BIT], 2);
	endproperty
	a_rewrite_active: assert property (p_rewrite_active) else $error("rewrite not applied");

	property p_ack_after_address;
		@(posedge i_clock) disable iff (!i_nrst)
		(state == st_addr && scl_fall && bit_count == VSRB_BITS_PER_BYTE
			&& shift[7:1] == p_slave_address && !bus_start && !bus_stop)
			|=> o_sda_oe && state == st_ack_addr;
	endproperty
	a_ack_after_address: assert property (p_ack_after_address) else $error("no address ack");

	property p_idle_released;
		@(posedge i_clock) disable iff (!i_nrst)
		state == st_idle |-> !o_sda_oe && !o_sda;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("line held in idle");

	c_write_setting: cover property (@(posedge i_clock) disable iff (!i_nrst)
		wr_en && pointer <= VSRB_ADDR_VOLTAGE_SETTING_3);
	c_read_byte: cover property (@(posedge i_clock) disable iff (!i_nrst)
		state == st_tx ##[1:400] state == st_mack);
	c_forced_pwm: cover property (@(posedge i_clock) disable iff (!i_nrst)
		$rose(o_forced_pwm));
endmodule : vsrb_top
`default_nettype wire
